// [rtl/smfp_defs.svh]
// constants of the standard midi file interpreter
`ifndef SMFP_DEFS_SVH
`define SMFP_DEFS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SMFP_A_CTRL 8'h00
`define SMFP_A_STATUS 8'h04
`define SMFP_A_DATA 8'h08
`define SMFP_A_IRQ_STAT 8'h0C
`define SMFP_A_IRQ_MASK 8'h10
`define SMFP_A_CH_SEL 8'h14
`define SMFP_A_CH_INFO 8'h18
`define SMFP_A_CH_BEND 8'h1C
`define SMFP_A_CH_EFF 8'h20
`define SMFP_A_TIMEBASE 8'h24
`define SMFP_A_GLOBAL 8'h28
`define SMFP_CTRL_PLAY 0
`define SMFP_CTRL_RESTART 1
`define SMFP_IRQ_ERR 0
`define SMFP_IRQ_DONE 1
`define SMFP_IRQ_GMON 2
`define SMFP_IRQ_W 3
// ----------------------------------------
// file structure checks
// ----------------------------------------
`define SMFP_TAG_HDR 32'h4D546864
`define SMFP_TAG_TRK 32'h4D54726B
`define SMFP_HDR_LEN 32'h00000006
`define SMFP_FMT 16'h0000
`define SMFP_NTRK 16'h0001
`define SMFP_TB_MIN 16'h0001
`define SMFP_TB_MAX 16'hFFFF
`define SMFP_CNT_W4 3'h3
`define SMFP_CNT_W2 3'h1
`define SMFP_VLQ_LAST 3'h4
`define SMFP_SYX_DEPTH 3'h7
`define SMFP_ERR_HID 4'h1
`define SMFP_ERR_HLEN 4'h2
`define SMFP_ERR_FMT 4'h3
`define SMFP_ERR_NTRK 4'h4
`define SMFP_ERR_TB 4'h5
`define SMFP_ERR_TID 4'h6
`define SMFP_ERR_VLQ 4'h7
// ----------------------------------------
// message codes
// ----------------------------------------
`define SMFP_MSG_NOTE_ON 4'h9
`define SMFP_MSG_CC 4'hB
`define SMFP_MSG_PROG 4'hC
`define SMFP_MSG_PRESS 4'hD
`define SMFP_MSG_BEND 4'hE
`define SMFP_STAT_SYX 8'hF0
`define SMFP_STAT_ESC 8'hF7
`define SMFP_STAT_META 8'hFF
`define SMFP_META_EOT 8'h2F
`define SMFP_CC_BANK 8'h00
`define SMFP_CC_VOL 8'h07
`define SMFP_CC_PAN 8'h0A
`define SMFP_CC_EXPR 8'h0B
`define SMFP_CC_RAC 8'h79
`define SMFP_X_UNIV 8'h7E
`define SMFP_X_GM 8'h09
`define SMFP_X_GM_ON 8'h01
`define SMFP_X_VEND0 8'h5D
`define SMFP_X_VEND1 8'h0E
`define SMFP_X_VEND2 8'h08
`define SMFP_X_TOUCH 8'h13
`define SMFP_X_EFF 8'h18
`define SMFP_X_PILE 8'h7C
// ----------------------------------------
// default values
// ----------------------------------------
`define SMFP_BANK_MEL 8'h79
`define SMFP_BANK_DRUM 8'h78
`define SMFP_BANK_ORIG 8'h77
`define SMFP_DRUM_CH 4'h9
`define SMFP_VOL 7'h64
`define SMFP_PAN 7'h40
`define SMFP_EXPR 7'h7F
`define SMFP_PROG 7'h00
`define SMFP_BEND_MSB 7'h40
`define SMFP_BEND_LSB 7'h00
`define SMFP_TOUCH 8'h00
`define SMFP_PILE 8'h01
`define SMFP_TONE_DRUM 14'h0080
`define SMFP_TONE_ORIG 14'h0088
`define SMFP_TONE_END 14'h0097
`endif

// [rtl/smfp_pkg.sv]
// types shared by the midi file interpreter
package smfp_pkg;
  typedef enum logic [3:0] {
    ACT_BANK, ACT_VOL, ACT_PAN, ACT_EXPR, ACT_PROG, ACT_BEND, ACT_RAC, ACT_GMON, ACT_EFF
  } smfp_act_kind_type;
  typedef struct packed {
    logic valid;
    smfp_act_kind_type kind;
    logic [3:0] ch;
    logic [15:0] val;
  } smfp_action_type;
  typedef struct packed {
    logic [7:0] bank;
    logic [6:0] vol;
    logic [6:0] pan;
    logic [6:0] expr;
    logic [6:0] prog;
    logic [13:0] bend;
    logic [7:0] eff_bank;
    logic [6:0] eff_prog;
  } smfp_chan_type;
  typedef enum logic [3:0] {
    S_HID, S_HLEN, S_FMT, S_NTRK, S_DIV, S_TID, S_TLEN, S_DELTA,
    S_STAT, S_DATA, S_META_T, S_LEN, S_SYX, S_DONE, S_ERR
  } smfp_state_type;
endpackage

// [rtl/smfp_vlq.sv]
// variable-length quantity decoder
`timescale 1ns/10ps
`include "smfp_defs.svh"
module smfp_vlq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic feed,
  input wire logic [7:0] din,
  output logic done,
  output logic ovf,
  output logic [27:0] value
);
  import smfp_pkg::*;
  logic [2:0] cnt_r;
  logic [27:0] acc_r;
  // only the low 28 bits are kept; a fifth byte shifts the top bits out
  assign value = {acc_r[20:0], din[6:0]};
  assign done = feed && !din[7];
  assign ovf = feed && din[7] && (cnt_r == `SMFP_VLQ_LAST);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      acc_r <= '0;
    end else if (clr || done || ovf) begin
      cnt_r <= '0;
      acc_r <= '0;
    end else if (feed) begin
      cnt_r <= cnt_r + 3'h1;
      acc_r <= value;
    end
  end
endmodule

// [rtl/smfp_chan.sv]
// per-channel playback parameter store
`timescale 1ns/10ps
`include "smfp_defs.svh"
module smfp_chan #(
  parameter int NCH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input smfp_pkg::smfp_action_type act,
  input wire logic [3:0] rd_ch,
  output smfp_pkg::smfp_chan_type rd
);
  import smfp_pkg::*;
  smfp_chan_type chan_r [NCH];

  function automatic smfp_chan_type chan_default(input logic [3:0] idx);
    smfp_chan_type c;
    c.bank = (idx == `SMFP_DRUM_CH) ? `SMFP_BANK_DRUM : `SMFP_BANK_MEL;
    c.vol = `SMFP_VOL;
    c.pan = `SMFP_PAN;
    c.expr = `SMFP_EXPR;
    c.prog = `SMFP_PROG;
    c.bend = {`SMFP_BEND_MSB, `SMFP_BEND_LSB};
    c.eff_bank = c.bank;
    c.eff_prog = `SMFP_PROG;
    return c;
  endfunction

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chan_r[i] <= chan_default(4'(i));
      end else if (act.valid && act.kind == ACT_GMON) begin
        // effect assignment survives the system-on message
        chan_r[i] <= chan_default(4'(i));
        chan_r[i].eff_bank <= chan_r[i].eff_bank;
        chan_r[i].eff_prog <= chan_r[i].eff_prog;
      end else if (act.valid && act.ch == 4'(i)) begin
        unique case (act.kind)
          ACT_BANK: chan_r[i].bank <= act.val[7:0];
          ACT_VOL: chan_r[i].vol <= act.val[6:0];
          ACT_PAN: chan_r[i].pan <= act.val[6:0];
          ACT_EXPR: chan_r[i].expr <= act.val[6:0];
          ACT_PROG: chan_r[i].prog <= act.val[6:0];
          ACT_BEND: chan_r[i].bend <= act.val[13:0];
          ACT_RAC: begin
            // bank, volume, pan and program stay as they are
            chan_r[i].expr <= `SMFP_EXPR;
            chan_r[i].bend <= {`SMFP_BEND_MSB, `SMFP_BEND_LSB};
          end
          ACT_EFF: begin
            chan_r[i].eff_bank <= act.val[15:8];
            chan_r[i].eff_prog <= act.val[6:0];
          end
          ACT_GMON: ;
        endcase
      end
    end
  end

  assign rd = chan_r[rd_ch];
endmodule

// [rtl/smfp_top.sv]
// standard midi file interpreter front end with apb registers
`timescale 1ns/10ps
`include "smfp_defs.svh"
module smfp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic sg_mute,
  output logic err_flag,
  output logic note_on,
  output logic [3:0] note_ch,
  output logic [6:0] note_key,
  output logic [6:0] note_vel
);
  import smfp_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  smfp_state_type st_r;
  smfp_state_type st_d_r;
  smfp_action_type act_r;
  smfp_action_type act_c;
  smfp_action_type syx_act_c;
  smfp_chan_type ch_rd;
  logic [2:0] cnt_r;
  logic [31:0] word_r;
  logic [31:0] wnext;
  logic [7:0] run_r;
  logic [7:0] d1_r;
  logic [27:0] len_r;
  logic eot_r;
  logic is_syx_r;
  logic syx_eval_r;
  logic [7:0] syx_r [7];
  logic [2:0] syx_cnt_r;
  logic [3:0] err_code_r;
  logic [15:0] tb_r;
  logic [7:0] touch_r;
  logic [7:0] pile_r;
  logic play_r;
  logic [3:0] ch_sel_r;
  logic [`SMFP_IRQ_W-1:0] stat_r;
  logic [`SMFP_IRQ_W-1:0] stat_nxt;
  logic [`SMFP_IRQ_W-1:0] mask_r;
  logic [`SMFP_IRQ_W-1:0] ev;
  logic [31:0] rd_c;
  logic acc;
  logic wr_en;
  logic restart;
  logic byte_v;
  logic [7:0] din;
  logic data_phase;
  logic one_w;
  logic msg_last;
  logic [7:0] m_d1;
  logic vlq_feed;
  logic vlq_done;
  logic vlq_ovf;
  logic [27:0] vlq_val;
  logic [13:0] tone;

  function automatic logic is_one(input logic [7:0] s);
    return (s[7:4] == `SMFP_MSG_PROG) || (s[7:4] == `SMFP_MSG_PRESS);
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `SMFP_A_CTRL, `SMFP_A_STATUS, `SMFP_A_DATA, `SMFP_A_IRQ_STAT, `SMFP_A_IRQ_MASK,
      `SMFP_A_CH_SEL, `SMFP_A_CH_INFO, `SMFP_A_CH_BEND, `SMFP_A_CH_EFF,
      `SMFP_A_TIMEBASE, `SMFP_A_GLOBAL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // one wait state so that read data and pready both leave flip-flops
  assign acc = psel && penable && pready;
  assign wr_en = acc && pwrite && !pslverr;
  assign restart = wr_en && (paddr == `SMFP_A_CTRL) && pwdata[`SMFP_CTRL_RESTART];

  always_comb begin
    rd_c = '0;
    case (paddr)
      `SMFP_A_CTRL: rd_c = 32'(play_r);
      `SMFP_A_STATUS: rd_c = 32'({err_code_r, 2'b00, st_r == S_DONE, st_r == S_ERR});
      `SMFP_A_IRQ_STAT: rd_c = 32'(stat_r);
      `SMFP_A_IRQ_MASK: rd_c = 32'(mask_r);
      `SMFP_A_CH_SEL: rd_c = 32'(ch_sel_r);
      `SMFP_A_CH_INFO: rd_c = {1'b0, ch_rd.prog, 1'b0, ch_rd.pan, 1'b0, ch_rd.vol, ch_rd.bank};
      `SMFP_A_CH_BEND: rd_c = 32'({ch_rd.expr, 2'b00, ch_rd.bend});
      `SMFP_A_CH_EFF: rd_c = 32'({ch_rd.eff_prog, ch_rd.eff_bank});
      `SMFP_A_TIMEBASE: rd_c = 32'(tb_r);
      `SMFP_A_GLOBAL: rd_c = 32'({pile_r, touch_r});
      default: rd_c = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok(paddr);
      prdata <= (psel && penable && !pready && !pwrite) ? rd_c : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      play_r <= 1'b0;
      ch_sel_r <= '0;
      mask_r <= '0;
    end else if (wr_en) begin
      if (paddr == `SMFP_A_CTRL) begin
        play_r <= pwdata[`SMFP_CTRL_PLAY];
      end
      if (paddr == `SMFP_A_CH_SEL) begin
        ch_sel_r <= pwdata[3:0];
      end
      if (paddr == `SMFP_A_IRQ_MASK) begin
        mask_r <= pwdata[`SMFP_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_comb begin
    ev = '0;
    ev[`SMFP_IRQ_ERR] = (st_r == S_ERR) && (st_d_r != S_ERR);
    ev[`SMFP_IRQ_DONE] = (st_r == S_DONE) && (st_d_r != S_DONE);
    ev[`SMFP_IRQ_GMON] = act_r.valid && (act_r.kind == ACT_GMON);
    stat_nxt = stat_r;
    if (wr_en && paddr == `SMFP_A_IRQ_STAT) begin
      stat_nxt = stat_r & ~pwdata[`SMFP_IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    stat_nxt = stat_nxt | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
      irq <= 1'b0;
      st_d_r <= S_HID;
      sg_mute <= 1'b0;
      err_flag <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq <= |(stat_nxt & mask_r);
      st_d_r <= st_r;
      sg_mute <= (st_r == S_ERR) && !restart;
      err_flag <= (st_r == S_ERR) && !restart;
    end
  end

  // ----------------------------------------
  // message decode
  // ----------------------------------------
  // intake stops after an error or after the end of the track
  assign din = pwdata[7:0];
  assign byte_v = wr_en && (paddr == `SMFP_A_DATA) && (st_r != S_ERR) && (st_r != S_DONE);
  assign wnext = {word_r[23:0], din};
  assign one_w = is_one(run_r);
  assign data_phase = (st_r == S_DATA) || ((st_r == S_STAT) && !din[7] && run_r[7]);
  assign msg_last = byte_v && data_phase && (one_w || cnt_r != '0);
  assign m_d1 = (cnt_r == '0) ? din : d1_r;
  assign vlq_feed = byte_v && ((st_r == S_DELTA) || (st_r == S_LEN));
  assign tone = {syx_r[6][6:0], syx_r[5][6:0]};

  smfp_vlq u_vlq (
    .pclk(pclk),
    .presetn(presetn),
    .clr(restart),
    .feed(vlq_feed),
    .din(din),
    .done(vlq_done),
    .ovf(vlq_ovf),
    .value(vlq_val)
  );

  always_comb begin
    act_c = '0;
    act_c.ch = run_r[3:0];
    act_c.val = 16'({din[6:0], m_d1[6:0]});
    case (run_r[7:4])
      `SMFP_MSG_CC: begin
        act_c.val = 16'(din);
        case (m_d1)
          `SMFP_CC_BANK: begin
            act_c.kind = ACT_BANK;
            act_c.valid = !play_r;
          end
          `SMFP_CC_VOL: begin
            act_c.kind = ACT_VOL;
            act_c.valid = 1'b1;
          end
          `SMFP_CC_PAN: begin
            act_c.kind = ACT_PAN;
            act_c.valid = 1'b1;
          end
          `SMFP_CC_EXPR: begin
            act_c.kind = ACT_EXPR;
            act_c.valid = 1'b1;
          end
          `SMFP_CC_RAC: begin
            act_c.kind = ACT_RAC;
            act_c.valid = 1'b1;
          end
          default: ;
        endcase
      end
      `SMFP_MSG_PROG: begin
        act_c.kind = ACT_PROG;
        act_c.valid = !play_r;
      end
      `SMFP_MSG_BEND: begin
        act_c.kind = ACT_BEND;
        act_c.valid = 1'b1;
      end
      default: ;
    endcase
  end

  // exclusive data is judged once its last byte is taken; only the first seven bytes are stored
  always_comb begin
    syx_act_c = '0;
    syx_act_c.ch = syx_r[4][3:0];
    syx_act_c.val[6:0] = (tone < `SMFP_TONE_DRUM) ? tone[6:0] : 7'(tone - `SMFP_TONE_DRUM);
    syx_act_c.val[15:8] = (tone < `SMFP_TONE_DRUM) ? `SMFP_BANK_MEL :
                          (tone < `SMFP_TONE_ORIG) ? `SMFP_BANK_DRUM : `SMFP_BANK_ORIG;
    if (syx_r[0] == `SMFP_X_UNIV && syx_r[2] == `SMFP_X_GM && syx_r[3] == `SMFP_X_GM_ON) begin
      syx_act_c.kind = ACT_GMON;
      syx_act_c.valid = 1'b1;
    end else if (syx_r[0] == `SMFP_X_VEND0 && syx_r[1] == `SMFP_X_VEND1 &&
                 syx_r[2] == `SMFP_X_VEND2 && syx_r[3] == `SMFP_X_EFF) begin
      syx_act_c.kind = ACT_EFF;
      syx_act_c.valid = !play_r && (tone < `SMFP_TONE_END);
    end
  end

  smfp_chan #(
    .NCH(16)
  ) u_chan (
    .pclk(pclk),
    .presetn(presetn),
    .act(act_r),
    .rd_ch(ch_sel_r),
    .rd(ch_rd)
  );

  // ----------------------------------------
  // file parser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_HID;
      cnt_r <= '0;
      word_r <= '0;
      run_r <= '0;
      d1_r <= '0;
      len_r <= '0;
      eot_r <= 1'b0;
      is_syx_r <= 1'b0;
      syx_eval_r <= 1'b0;
      syx_cnt_r <= '0;
      syx_r <= '{default: '0};
      err_code_r <= '0;
      tb_r <= '0;
      touch_r <= `SMFP_TOUCH;
      pile_r <= `SMFP_PILE;
      act_r <= '0;
      note_on <= 1'b0;
      note_ch <= '0;
      note_key <= '0;
      note_vel <= '0;
    end else begin
      syx_eval_r <= 1'b0;
      note_on <= 1'b0;
      act_r <= msg_last ? act_c : (syx_eval_r ? syx_act_c : '0);
      if (syx_eval_r && !play_r && syx_r[0] == `SMFP_X_VEND0 && syx_r[1] == `SMFP_X_VEND1 &&
          syx_r[2] == `SMFP_X_VEND2) begin
        if (syx_r[3] == `SMFP_X_TOUCH) begin
          touch_r <= syx_r[4];
        end
        if (syx_r[3] == `SMFP_X_PILE) begin
          pile_r <= syx_r[4];
        end
      end
      // no range filter on the key: out-of-range notes still sound
      if (msg_last && run_r[7:4] == `SMFP_MSG_NOTE_ON) begin
        note_on <= 1'b1;
        note_ch <= run_r[3:0];
        note_key <= m_d1[6:0];
        note_vel <= din[6:0];
      end
      if (restart) begin
        st_r <= S_HID;
        cnt_r <= '0;
        run_r <= '0;
        err_code_r <= '0;
      end else if (byte_v) begin
        word_r <= wnext;
        cnt_r <= cnt_r + 3'h1;
        unique case (st_r)
          S_HID, S_HLEN, S_TID: begin
            if (cnt_r == `SMFP_CNT_W4) begin
              cnt_r <= '0;
              if (st_r == S_HID && wnext != `SMFP_TAG_HDR) begin
                st_r <= S_ERR;
                err_code_r <= `SMFP_ERR_HID;
              end else if (st_r == S_HLEN && wnext != `SMFP_HDR_LEN) begin
                st_r <= S_ERR;
                err_code_r <= `SMFP_ERR_HLEN;
              end else if (st_r == S_TID && wnext != `SMFP_TAG_TRK) begin
                st_r <= S_ERR;
                err_code_r <= `SMFP_ERR_TID;
              end else begin
                st_r <= (st_r == S_HID) ? S_HLEN : ((st_r == S_HLEN) ? S_FMT : S_TLEN);
              end
            end
          end
          S_FMT, S_NTRK, S_DIV: begin
            if (cnt_r == `SMFP_CNT_W2) begin
              cnt_r <= '0;
              if (st_r == S_FMT && wnext[15:0] != `SMFP_FMT) begin
                st_r <= S_ERR;
                err_code_r <= `SMFP_ERR_FMT;
              end else if (st_r == S_NTRK && wnext[15:0] != `SMFP_NTRK) begin
                st_r <= S_ERR;
                err_code_r <= `SMFP_ERR_NTRK;
              end else if (st_r == S_DIV &&
                           (wnext[15:0] < `SMFP_TB_MIN || wnext[15:0] > `SMFP_TB_MAX)) begin
                st_r <= S_ERR;
                err_code_r <= `SMFP_ERR_TB;
              end else begin
                if (st_r == S_DIV) begin
                  tb_r <= wnext[15:0];
                end
                st_r <= (st_r == S_FMT) ? S_NTRK : ((st_r == S_NTRK) ? S_DIV : S_TID);
              end
            end
          end
          S_TLEN: begin
            if (cnt_r == `SMFP_CNT_W4) begin
              st_r <= S_DELTA;
            end
          end
          S_DELTA, S_LEN: begin
            cnt_r <= '0;
            if (vlq_ovf) begin
              st_r <= S_ERR;
              err_code_r <= `SMFP_ERR_VLQ;
            end else if (vlq_done && st_r == S_DELTA) begin
              st_r <= S_STAT;
            end else if (vlq_done) begin
              len_r <= vlq_val;
              st_r <= (vlq_val != '0) ? S_SYX : (eot_r ? S_DONE : S_DELTA);
            end
          end
          S_STAT, S_DATA: begin
            cnt_r <= '0;
            if (msg_last) begin
              st_r <= S_DELTA;
            end else if (data_phase) begin
              d1_r <= din;
              cnt_r <= 3'h1;
              st_r <= S_DATA;
            end else if (din == `SMFP_STAT_SYX || din == `SMFP_STAT_ESC) begin
              is_syx_r <= (din == `SMFP_STAT_SYX);
              eot_r <= 1'b0;
              syx_cnt_r <= '0;
              // a short message must not be judged on bytes of the one before it
              syx_r <= '{default: '0};
              st_r <= S_LEN;
            end else if (din == `SMFP_STAT_META) begin
              st_r <= S_META_T;
            end else if (din[7] && din < `SMFP_STAT_SYX) begin
              run_r <= din;
              st_r <= S_DATA;
            end else begin
              st_r <= S_DELTA;
            end
          end
          S_META_T: begin
            is_syx_r <= 1'b0;
            eot_r <= (din == `SMFP_META_EOT);
            st_r <= S_LEN;
          end
          S_SYX: begin
            if (is_syx_r && syx_cnt_r != `SMFP_SYX_DEPTH) begin
              syx_r[syx_cnt_r] <= din;
              syx_cnt_r <= syx_cnt_r + 3'h1;
            end
            len_r <= len_r - 28'h1;
            if (len_r == 28'h1) begin
              syx_eval_r <= is_syx_r;
              st_r <= eot_r ? S_DONE : S_DELTA;
            end
          end
          S_DONE, S_ERR: ;
        endcase
      end
    end
  end
endmodule

// [testbench/smfp_chk.sv]
// assertions on the interpreter ports
`timescale 1ns/10ps
module smfp_chk (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic irq,
  input logic sg_mute,
  input logic err_flag,
  input logic note_on
);
  // ------
  // checks
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a file byte is taken only at this edge
  wire dw = psel && penable && pready && pwrite && paddr == 8'h08;
  mute_err_a: assert property (sg_mute == err_flag)
    else $error("mute differs from error flag");
  err_hold_a: assert property (err_flag && !psel |=> err_flag)
    else $error("error dropped without bus access");
  err_src_a: assert property ($rose(err_flag) |-> $past(dw, 2))
    else $error("error not caused by a file byte");
  no_note_a: assert property (err_flag |-> !note_on)
    else $error("note played while stopped");
  note_src_a: assert property (note_on |-> $past(dw) ##1 !note_on)
    else $error("note pulse without byte or too long");
  rdy_once_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  wait_one_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("answer not after one wait state");
  slv_err_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  cover property ($rose(err_flag));
  cover property (note_on);
  cover property ($rose(irq));
endmodule

// [testbench/smfp_host.sv]
// apb master standing in for the host processor
`timescale 1ns/10ps
module smfp_host (
  input logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr
);
  // ------
  // bus cycle
  // ------
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
  end
  // request held until pready is seen; only the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule

// [testbench/tb.sv]
// self-checking bench for the midi file interpreter
`timescale 1ns/10ps
module tb;
  // ------
  // harness
  // ------
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  wire psel, penable, pwrite, pready, pslverr, irq, sg_mute, err_flag, note_on;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] note_ch;
  wire [6:0] note_key, note_vel;
  int fail_count = 0;
  int total_checks = 0;
  int nn = 0;
  logic [17:0] nv;
  logic [31:0] q;
  logic e;
  logic [239:0] s;
  logic [175:0] hdr = 176'h4D546864_00000006_0000_0001_0060_4D54726B_00000100;
  smfp_top i_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .sg_mute, .err_flag, .note_on, .note_ch, .note_key, .note_vel);
  smfp_host h(.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) if (note_on === 1'h1) begin
    nn++;
    nv = {note_ch, note_key, note_vel};
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    h.xfer(1'h1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a);
    h.xfer(1'h0, a, 32'h0, q, e);
  endtask
  task fb(input int n);
    for (int i = 0; i < n; i++) wr(8'h08, {24'h0, s[239 - 8 * i -: 8]});
  endtask
  task fw(input logic [31:0] w[$]);
    foreach (w[j]) for (int i = 3; i >= 0; i--) wr(8'h08, {24'h0, w[j][8 * i +: 8]});
  endtask
  task chk_ch(input logic [3:0] c, input logic [31:0] m, i, b, f);
    wr(8'h14, {28'h0, c});
    rd(8'h18);
    chk(q & m, i);
    rd(8'h1C);
    chk(q, b);
    rd(8'h20);
    chk(q, f);
  endtask
  // ------
  // scenarios
  // ------
  task t_dflt;
    chk_ch(4'h9, 32'hFFFFFFFF, 32'h00406478, 32'h007F2000, 32'h78);
    chk_ch(4'h0, 32'hFFFFFFFF, 32'h00406479, 32'h007F2000, 32'h79);
    rd(8'h3C);
    chk({e, q[30:0]}, 32'h80000000);
    $display("defaults done");
  endtask
  task t_err;
    int ix[8] = '{0, 7, 9, 11, 13, 17, 22, 22};
    logic [7:0] vl[8] = '{8'h0, 8'h7, 8'h1, 8'h2, 8'h0, 8'h0, 8'h80, 8'h0};
    int nb[8] = '{4, 8, 10, 12, 14, 18, 28, 30};
    int ec[8] = '{1, 2, 3, 4, 5, 6, 7, 7};
    wr(8'h10, 32'h1);
    for (int k = 0; k < 8; k++) begin
      s = {hdr, 64'h00F0808080808080};
      s[239 - 8 * ix[k] -: 8] = vl[k];
      wr(8'h00, 32'h2);
      wr(8'h0C, 32'h7);
      fb(nb[k]);
      rd(8'h04);
      chk(q[7:0], {ec[k][3:0], 4'h1});
      chk({irq, sg_mute, err_flag}, 3'h7);
    end
    // bytes after a shutdown must not reach the generator
    fw({32'h00903C40});
    chk(nn, 0);
    wr(8'h0C, 32'h1);
    rd(8'h04);
    chk(irq, 1'h0);
    $display("errors done");
  endtask
  task t_run;
    wr(8'h00, 32'h2);
    s = {hdr, 64'h0};
    fb(22);
    rd(8'h24);
    chk(q, 32'h60);
    // the touch message also carries a four-byte delta time
    fw({32'h00B30710, 32'h00B30A20, 32'h00B30005, 32'h00E31122, 32'h00C30600,
      32'hB30B3080, 32'h00B90007, 32'h8000F008, 32'h5D0E0818, 32'h030500F7,
      32'h80808000, 32'hF0065D0E, 32'h081305F7});
    chk_ch(4'h3, 32'hFFFFFFFF, 32'h06201005, 32'h00301111, 32'h579);
    fw({32'h00B37900});
    chk_ch(4'h3, 32'hFFFFFFFF, 32'h06201005, 32'h007F2000, 32'h579);
    fw({32'h00F0057E, 32'h7F0901F7});
    chk_ch(4'h9, 32'hFFFFFFFF, 32'h00406478, 32'h007F2000, 32'h78);
    chk_ch(4'h3, 32'hFFFFFFFF, 32'h00406479, 32'h007F2000, 32'h579);
    wr(8'h00, 32'h1);
    fw({32'h00B30001, 32'h8000C309, 32'h00B30711, 32'h00B30B22, 32'h00F0085D,
      32'h0E081803, 32'h0700F780, 32'h0093057F, 32'h808000F0, 32'h075D0E08, 32'h7C0300F7});
    chk_ch(4'h3, 32'hFFFFFFFF, 32'h00401179, 32'h00222000, 32'h579);
    chk(nn, 1);
    chk(nv, {4'h3, 7'h05, 7'h7F});
    rd(8'h28);
    chk(q, 32'h105);
    fw({32'h00FF2F00});
    rd(8'h04);
    chk(q[1:0], 2'h2);
    wr(8'h00, 32'h0);
    $display("playback done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_dflt;
    t_err;
    t_run;
    wrap_up;
  end
  initial begin
    #400000;
    fail_count++;
    wrap_up;
  end
endmodule
bind smfp_top smfp_chk u_chk(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .irq, .sg_mute, .err_flag, .note_on);
